// ---- inc/pin_share_consts.svh ----
/*
 constants of the pin sharing block: register offsets, field positions, reset values.
 assumes a 12-bit byte address on the register bus.
*/
`ifndef PIN_SHARE_CONSTS_SVH
`define PIN_SHARE_CONSTS_SVH

`define PS_ADDR_W 12
`define PS_F_W 7
`define PS_F_LO 9
`define PS_F_HI 15
`define PS_BIT_DRIVE_SEL 0
`define PS_BIT_B0 0

`define PS_OFF_BUS_CTRL 12'h000
`define PS_OFF_B_FUNC 12'h004
`define PS_OFF_B_DIR 12'h008
`define PS_OFF_B_DOUT 12'h00c
`define PS_OFF_B_PULL 12'h010
`define PS_OFF_B_PIN 12'h014
`define PS_OFF_F_FUNC 12'h018
`define PS_OFF_F_DIR 12'h01c
`define PS_OFF_F_DOUT 12'h020
`define PS_OFF_F_PULL 12'h024
`define PS_OFF_F_PIN 12'h028

`define PS_RST_DRIVE_SEL 1'h0
`define PS_RST_FUNC_B 1'h0
`define PS_RST_PULL_B 1'h1
`define PS_RST_FUNC_F 7'h7f
`define PS_RST_PULL_F 7'h7f

`endif

// ---- inc/pin_share_pkg.sv ----
/*
 types of the pin sharing block.
 assumes nothing of its surroundings.
*/
package pin_share_pkg;
	typedef enum logic [1:0] {
		ST_FILL0 = 2'b00,
		ST_FILL1 = 2'b01,
		ST_ARM = 2'b10,
		ST_RUN = 2'b11
	} strap_state_t;
endpackage

// ---- inc/pad_cfg_if.sv ----
/*
 carrier between the register side and one group of shared pads.
 assumes the controller drives configuration and the mux drives pad levels.
*/
interface pad_cfg_if #(parameter int W = 1);
	logic [W-1:0] func;
	logic [W-1:0] dir;
	logic [W-1:0] dout;
	logic [W-1:0] pull;
	logic [W-1:0] mem_o;
	logic [W-1:0] mem_oe;
	logic [W-1:0] pad_o;
	logic [W-1:0] pad_oe;
	logic [W-1:0] pad_pu;
	modport ctrl (output func, dir, dout, pull, mem_o, mem_oe, input pad_o, pad_oe, pad_pu);
	modport mux (input func, dir, dout, pull, mem_o, mem_oe, output pad_o, pad_oe, pad_pu);
endinterface

// ---- logic/pad_mux.sv ----
/*
 registered pad mux: selects memory bus or port drive per pin.
 assumes configuration is synchronous to clk_sys.
*/
module pad_mux #(parameter int W = 1) (
	input wire logic clk_sys,
	input wire logic rst_n,
	pad_cfg_if.mux cfg
);
	logic [W-1:0] o_d;
	logic [W-1:0] oe_d;
	logic [W-1:0] pu_d;
	logic [W-1:0] o_q;
	logic [W-1:0] oe_q;
	logic [W-1:0] pu_q;

	always_comb begin
		// memory function or port function per pin
		o_d = (cfg.func & cfg.mem_o) | (~cfg.func & cfg.dout);
		// port input leaves the driver off
		oe_d = (cfg.func & cfg.mem_oe) | (~cfg.func & cfg.dir);
		pu_d = cfg.pull;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_q <= '0;
			oe_q <= '0;
			pu_q <= '1;
		end else begin
			o_q <= o_d;
			oe_q <= oe_d;
			pu_q <= pu_d;
		end
	end

	assign cfg.pad_o = o_q;
	assign cfg.pad_oe = oe_q;
	assign cfg.pad_pu = pu_q;
endmodule

// ---- logic/pin_share_top.sv ----
/*
 pin sharing of the upper address pin and seven low data pins, with apb registers.
 assumes the memory bus controller and apb master run on clk_sys; pads and straps are async.
*/
`include "pin_share_consts.svh"
module pin_share_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_boot_select,
	input wire logic memory_interface_mode,
	input wire logic flash_secured,
	input wire logic mem_bus_active,
	input wire logic mem_wr_drive,
	input wire logic mem_addr_hi,
	input wire logic [`PS_F_W-1:0] mem_wdata,
	output logic [`PS_F_W-1:0] mem_rdata,
	input wire logic pad_b_i,
	output logic pad_b_o,
	output logic pad_b_oe,
	output logic pad_b_pu,
	input wire logic [`PS_F_W-1:0] pad_f_i,
	output logic [`PS_F_W-1:0] pad_f_o,
	output logic [`PS_F_W-1:0] pad_f_oe,
	output logic [`PS_F_W-1:0] pad_f_pu
);
	localparam int FW = `PS_F_W;

	pin_share_pkg::strap_state_t state_q;
	pin_share_pkg::strap_state_t state_d;
	logic drive_sel_q, drive_sel_d;
	logic func_b_q, func_b_d;
	logic dir_b_q, dir_b_d;
	logic dout_b_q, dout_b_d;
	logic pull_b_q, pull_b_d;
	logic [FW-1:0] func_f_q, func_f_d;
	logic [FW-1:0] dir_f_q, dir_f_d;
	logic [FW-1:0] dout_f_q, dout_f_d;
	logic [FW-1:0] pull_f_q, pull_f_d;
	logic addr_hold_q, addr_hold_d;
	logic [FW-1:0] data_hold_q, data_hold_d;
	logic [FW-1:0] rdata_q, rdata_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [2:0] strap_s1_q, strap_s2_q;
	logic pin_b_s1_q, pin_b_s2_q;
	logic [FW-1:0] pin_f_s1_q, pin_f_s2_q;
	logic strap_pick;
	logic wr_en;
	logic rd_take;

	function automatic logic hit(input logic [`PS_ADDR_W-1:0] a, input logic [`PS_ADDR_W-1:0] o);
		return a == o;
	endfunction

	function automatic logic mapped(input logic [`PS_ADDR_W-1:0] a);
		return hit(a, `PS_OFF_BUS_CTRL) || hit(a, `PS_OFF_B_FUNC) || hit(a, `PS_OFF_B_DIR)
			|| hit(a, `PS_OFF_B_DOUT) || hit(a, `PS_OFF_B_PULL) || hit(a, `PS_OFF_B_PIN)
			|| hit(a, `PS_OFF_F_FUNC) || hit(a, `PS_OFF_F_DIR) || hit(a, `PS_OFF_F_DOUT)
			|| hit(a, `PS_OFF_F_PULL) || hit(a, `PS_OFF_F_PIN);
	endfunction

	// port f fields sit at bits 15:9
	function automatic logic [31:0] fword(input logic [FW-1:0] v);
		return {16'h0000, v, 9'h000};
	endfunction

	// two-stage synchronisers for straps and pad inputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1_q <= 3'h0;
			strap_s2_q <= 3'h0;
			pin_b_s1_q <= 1'h0;
			pin_b_s2_q <= 1'h0;
			pin_f_s1_q <= 7'h00;
			pin_f_s2_q <= 7'h00;
		end else begin
			strap_s1_q <= {external_boot_select, memory_interface_mode, flash_secured};
			strap_s2_q <= strap_s1_q;
			pin_b_s1_q <= pad_b_i;
			pin_b_s2_q <= pin_b_s1_q;
			pin_f_s1_q <= pad_f_i;
			pin_f_s2_q <= pin_f_s1_q;
		end
	end

	// address function on external boot, or memory mode when not secured
	assign strap_pick = strap_s2_q[2] | (strap_s2_q[1] & ~strap_s2_q[0]);
	assign wr_en = psel & penable & pready_q & pwrite;
	assign rd_take = psel & penable & ~pready_q;

	always_comb begin
		state_d = state_q;
		drive_sel_d = drive_sel_q;
		func_b_d = func_b_q;
		dir_b_d = dir_b_q;
		dout_b_d = dout_b_q;
		pull_b_d = pull_b_q;
		func_f_d = func_f_q;
		dir_f_d = dir_f_q;
		dout_f_d = dout_f_q;
		pull_f_d = pull_f_q;
		unique case (state_q)
			pin_share_pkg::ST_FILL0: state_d = pin_share_pkg::ST_FILL1;
			pin_share_pkg::ST_FILL1: state_d = pin_share_pkg::ST_ARM;
			pin_share_pkg::ST_ARM: begin
				state_d = pin_share_pkg::ST_RUN;
				func_b_d = strap_pick;
			end
			pin_share_pkg::ST_RUN: state_d = pin_share_pkg::ST_RUN;
		endcase
		if (wr_en) begin
			if (hit(paddr, `PS_OFF_BUS_CTRL)) begin
				drive_sel_d = pwdata[`PS_BIT_DRIVE_SEL];
			end
			if (hit(paddr, `PS_OFF_B_FUNC)) begin
				func_b_d = pwdata[`PS_BIT_B0];
			end
			if (hit(paddr, `PS_OFF_B_DIR)) begin
				dir_b_d = pwdata[`PS_BIT_B0];
			end
			if (hit(paddr, `PS_OFF_B_DOUT)) begin
				dout_b_d = pwdata[`PS_BIT_B0];
			end
			if (hit(paddr, `PS_OFF_B_PULL)) begin
				pull_b_d = pwdata[`PS_BIT_B0];
			end
			if (hit(paddr, `PS_OFF_F_FUNC)) begin
				func_f_d = pwdata[`PS_F_HI:`PS_F_LO];
			end
			if (hit(paddr, `PS_OFF_F_DIR)) begin
				dir_f_d = pwdata[`PS_F_HI:`PS_F_LO];
			end
			if (hit(paddr, `PS_OFF_F_DOUT)) begin
				dout_f_d = pwdata[`PS_F_HI:`PS_F_LO];
			end
			if (hit(paddr, `PS_OFF_F_PULL)) begin
				pull_f_d = pwdata[`PS_F_HI:`PS_F_LO];
			end
		end
	end

	// apb answer one wait state after the access phase begins
	always_comb begin
		pready_d = rd_take;
		prdata_d = prdata_q;
		pslverr_d = 1'h0;
		if (rd_take) begin
			pslverr_d = ~mapped(paddr);
			prdata_d = 32'h00000000;
			if (!pwrite) begin
				if (hit(paddr, `PS_OFF_BUS_CTRL)) prdata_d = {31'h00000000, drive_sel_q};
				if (hit(paddr, `PS_OFF_B_FUNC)) prdata_d = {31'h00000000, func_b_q};
				if (hit(paddr, `PS_OFF_B_DIR)) prdata_d = {31'h00000000, dir_b_q};
				if (hit(paddr, `PS_OFF_B_DOUT)) prdata_d = {31'h00000000, dout_b_q};
				if (hit(paddr, `PS_OFF_B_PULL)) prdata_d = {31'h00000000, pull_b_q};
				if (hit(paddr, `PS_OFF_B_PIN)) prdata_d = {31'h00000000, pin_b_s2_q};
				if (hit(paddr, `PS_OFF_F_FUNC)) prdata_d = fword(func_f_q);
				if (hit(paddr, `PS_OFF_F_DIR)) prdata_d = fword(dir_f_q);
				if (hit(paddr, `PS_OFF_F_DOUT)) prdata_d = fword(dout_f_q);
				if (hit(paddr, `PS_OFF_F_PULL)) prdata_d = fword(pull_f_q);
				if (hit(paddr, `PS_OFF_F_PIN)) prdata_d = fword(pin_f_s2_q);
			end
		end
	end

	// last bus values kept for driving an idle bus, and memory read data from the pins
	always_comb begin
		addr_hold_d = mem_bus_active ? mem_addr_hi : addr_hold_q;
		data_hold_d = (mem_bus_active && mem_wr_drive) ? mem_wdata : data_hold_q;
		rdata_d = pin_f_s2_q;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pin_share_pkg::ST_FILL0;
			drive_sel_q <= `PS_RST_DRIVE_SEL;
			func_b_q <= `PS_RST_FUNC_B;
			dir_b_q <= 1'h0;
			dout_b_q <= 1'h0;
			pull_b_q <= `PS_RST_PULL_B;
			func_f_q <= `PS_RST_FUNC_F;
			dir_f_q <= 7'h00;
			dout_f_q <= 7'h00;
			pull_f_q <= `PS_RST_PULL_F;
			addr_hold_q <= 1'h0;
			data_hold_q <= 7'h00;
			rdata_q <= 7'h00;
			prdata_q <= 32'h00000000;
			pready_q <= 1'h0;
			pslverr_q <= 1'h0;
		end else begin
			state_q <= state_d;
			drive_sel_q <= drive_sel_d;
			func_b_q <= func_b_d;
			dir_b_q <= dir_b_d;
			dout_b_q <= dout_b_d;
			pull_b_q <= pull_b_d;
			func_f_q <= func_f_d;
			dir_f_q <= dir_f_d;
			dout_f_q <= dout_f_d;
			pull_f_q <= pull_f_d;
			addr_hold_q <= addr_hold_d;
			data_hold_q <= data_hold_d;
			rdata_q <= rdata_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	pad_cfg_if #(.W(1)) cfg_b ();
	pad_cfg_if #(.W(FW)) cfg_f ();

	assign cfg_b.func = func_b_q;
	assign cfg_b.dir = dir_b_q;
	assign cfg_b.dout = dout_b_q;
	assign cfg_b.pull = pull_b_q;
	assign cfg_b.mem_o = mem_bus_active ? mem_addr_hi : addr_hold_q;
	assign cfg_b.mem_oe = mem_bus_active | drive_sel_q;
	assign cfg_f.func = func_f_q;
	assign cfg_f.dir = dir_f_q;
	assign cfg_f.dout = dout_f_q;
	assign cfg_f.pull = pull_f_q;
	assign cfg_f.mem_o = mem_bus_active ? mem_wdata : data_hold_q;
	assign cfg_f.mem_oe = mem_bus_active ? {FW{mem_wr_drive}} : {FW{drive_sel_q}};

	pad_mux #(.W(1)) u_mux_b (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cfg(cfg_b)
	);

	pad_mux #(.W(FW)) u_mux_f (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cfg(cfg_f)
	);

	assign pad_b_o = cfg_b.pad_o;
	assign pad_b_oe = cfg_b.pad_oe;
	assign pad_b_pu = cfg_b.pad_pu;
	assign pad_f_o = cfg_f.pad_o;
	assign pad_f_oe = cfg_f.pad_oe;
	assign pad_f_pu = cfg_f.pad_pu;
	assign mem_rdata = rdata_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_B_PORT_OUT: assert property (
		(!func_b_q && dir_b_q) |=> (pad_b_oe && pad_b_o == $past(dout_b_q)))
		else $error("port b output not driven");
	AST_B_ADDR: assert property (
		(func_b_q && mem_bus_active) |=> (pad_b_oe && pad_b_o == $past(mem_addr_hi)))
		else $error("address line not carried");
	AST_B_IDLE_FLOAT: assert property (
		(func_b_q && !mem_bus_active && !drive_sel_q) |=> !pad_b_oe)
		else $error("idle address pin driven");
	AST_STRAP_CAPTURE: assert property (
		(state_q == pin_share_pkg::ST_ARM) |=> (func_b_q == $past(strap_pick)))
		else $error("start-up function not taken from straps");
	AST_B_FUNC_WRITE: assert property (
		(wr_en && paddr == `PS_OFF_B_FUNC && state_q == pin_share_pkg::ST_RUN)
		|=> (func_b_q == $past(pwdata[0])))
		else $error("function write lost");
	AST_B_PULL_OFF: assert property (
		(!pull_b_q) |=> !pad_b_pu)
		else $error("port b pull-up still on");
	AST_F_WRITE_DRIVE: assert property (
		(func_f_q == 7'h7f && mem_bus_active && mem_wr_drive)
		|=> (pad_f_oe == 7'h7f && pad_f_o == $past(mem_wdata)))
		else $error("data lines not driven in write");
	AST_F_IDLE_FLOAT: assert property (
		(func_f_q == 7'h7f && !mem_bus_active && !drive_sel_q) |=> (pad_f_oe == 7'h00))
		else $error("idle data lines driven");
	AST_F_PORT_DIR: assert property (
		(func_f_q == 7'h00) |=> (pad_f_oe == $past(dir_f_q)))
		else $error("port f direction not applied");
	AST_F_RESET_FUNC: assert property (
		(state_q == pin_share_pkg::ST_FILL0) |-> (func_f_q == 7'h7f))
		else $error("data lines not in memory function after reset");
	AST_F_PULL_OFF: assert property (
		(!pull_f_q[0]) |=> !pad_f_pu[0])
		else $error("first data line pull-up still on");
	AST_B_INPUT_OFF: assert property (
		(!func_b_q && !dir_b_q)[*2] |-> !pad_b_oe)
		else $error("port input drives pin");
endmodule

// ---- verif/ext_memory.sv ----
/*
 external memory and board wiring seen from the shared pads.
 assumes pad controls come registered on clk_sys.
*/
module ext_memory (
	input wire logic clk_sys,
	input wire logic active,
	input wire logic wr,
	input wire logic [6:0] rd_val,
	input wire logic [6:0] f_o,
	input wire logic [6:0] f_oe,
	input wire logic [6:0] f_pu,
	input wire logic b_o,
	input wire logic b_oe,
	input wire logic b_pu,
	input wire logic b_drv_en,
	input wire logic b_drv,
	output logic [6:0] f_i,
	output logic b_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip;
	initial flip = 1'b0;
	// undriven floating pins change every cycle
	always @(posedge clk_sys) flip <= ~flip;
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (f_oe[i])
				f_i[i] = f_o[i];
			else if (active && !wr)
				f_i[i] = rd_val[i];
			else
				f_i[i] = f_pu[i] ? 1'b1 : flip;
		end
		if (b_oe)
			b_i = b_o;
		else if (b_drv_en)
			b_i = b_drv;
		else
			b_i = b_pu ? 1'b1 : flip;
	end
endmodule

// ---- verif/testbench.sv ----
/*
 self-checking bench of the pin sharing block.
 assumes the constants header is on the include path.
*/
`include "pin_share_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v, u;
	logic eb, mode, sec, active, wr, a_hi, b_en, b_drv, b_o, b_oe, b_pu, b_i;
	logic [6:0] wdata, rdata, f_o, f_oe, f_pu, f_i, rd_val;
	logic [32:0] exp_q[$];
	int bad_count, checks, seed, k;
	pin_share_top i_pin_share_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_boot_select(eb),
		.memory_interface_mode(mode), .flash_secured(sec), .mem_bus_active(active),
		.mem_wr_drive(wr), .mem_addr_hi(a_hi), .mem_wdata(wdata), .mem_rdata(rdata),
		.pad_b_i(b_i), .pad_b_o(b_o), .pad_b_oe(b_oe), .pad_b_pu(b_pu), .pad_f_i(f_i),
		.pad_f_o(f_o), .pad_f_oe(f_oe), .pad_f_pu(f_pu));
	ext_memory i_ext_memory (.clk_sys(clk_sys), .active(active), .wr(wr), .rd_val(rd_val),
		.f_o(f_o), .f_oe(f_oe), .f_pu(f_pu), .b_o(b_o), .b_oe(b_oe), .b_pu(b_pu),
		.b_drv_en(b_en), .b_drv(b_drv), .f_i(f_i), .b_i(b_i));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic compare(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// read answers are taken off the queue in arrival order
	always @(posedge clk_sys) if (psel && penable && pready === 1'b1 && !pwrite) begin
		compare({pslverr, prdata}, exp_q.pop_front());
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20)
			bad_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wrr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic complete_run;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		complete_run;
	end
	initial begin
		seed = 86;
		{rst_n, psel, penable, pwrite, paddr, pwdata, eb, mode, sec} = '0;
		{active, wr, a_hi, wdata, rd_val, b_en, b_drv} = '0;
		for (k = 0; k < 8; k++) begin
			{eb, mode, sec} <= k[2:0];
			rst_n <= 1'b0;
			settle(5);
			rst_n <= 1'b1;
			settle(4);
			rd(`PS_OFF_B_FUNC, {32'h0, eb | (mode & !sec)});
		end
		compare({b_pu, f_oe, f_pu}, {1'b1, 7'h0, 7'h7f});
		rd(`PS_OFF_F_FUNC, 33'h7f << 9);
		rd(12'h030, {1'b1, 32'h0});
		wrr(`PS_OFF_B_FUNC, 32'h0);
		wrr(`PS_OFF_B_DIR, 32'h0);
		v = $random(seed);
		b_en <= 1'b1;
		b_drv <= v[0];
		settle(5);
		compare(33'(b_oe), 33'h0);
		rd(`PS_OFF_B_PIN, {32'h0, v[0]});
		b_en <= 1'b0;
		wrr(`PS_OFF_B_DIR, 32'h1);
		wrr(`PS_OFF_B_DOUT, {31'h0, ~v[0]});
		settle(2);
		compare({b_oe, b_o}, {1'b1, ~v[0]});
		wrr(`PS_OFF_B_PULL, 32'h0);
		wrr(`PS_OFF_F_PULL, v & 32'hfe00);
		settle(2);
		compare({b_pu, f_pu}, {1'b0, v[15:9]});
		wrr(`PS_OFF_B_FUNC, 32'h1);
		active <= 1'b1;
		a_hi <= 1'b1;
		settle(3);
		compare({b_oe, b_o}, 2'b11);
		active <= 1'b0;
		settle(3);
		compare(33'(b_oe), 33'h0);
		wrr(`PS_OFF_BUS_CTRL, 32'h1);
		settle(2);
		compare({b_oe, b_o}, 2'b11);
		active <= 1'b1;
		wr <= 1'b1;
		wdata <= v[22:16];
		settle(3);
		compare({f_oe, f_o}, {7'h7f, v[22:16]});
		wr <= 1'b0;
		rd_val <= v[29:23];
		settle(6);
		compare({f_oe, rdata}, {7'h0, v[29:23]});
		active <= 1'b0;
		settle(3);
		compare(33'(f_oe), 33'h7f);
		wrr(`PS_OFF_BUS_CTRL, 32'h0);
		settle(2);
		compare(33'(f_oe), 33'h0);
		u = $random(seed);
		wrr(`PS_OFF_F_PULL, 32'h0);
		settle(2);
		compare(33'(f_pu), 33'h0);
		wrr(`PS_OFF_F_PULL, 32'hfe00);
		wrr(`PS_OFF_F_FUNC, 32'h0);
		wrr(`PS_OFF_F_DIR, v & 32'hfe00);
		wrr(`PS_OFF_F_DOUT, u & 32'hfe00);
		settle(2);
		compare({f_oe, f_o & v[15:9]}, {v[15:9], u[15:9] & v[15:9]});
		settle(4);
		rd(`PS_OFF_F_PIN, {17'h00000, (u[15:9] & v[15:9]) | ~v[15:9], 9'h000});
		settle(2);
		complete_run;
	end
endmodule
